// [core/fcg_fanout_gate.sv]
// Functional notes
// [RULE_01] Output enable low puts every fanout output in high impedance.
// [RULE_02] Enabled but gated: true outputs low, complement outputs high.
// [RULE_03] Enabled and running: every pair follows the selected input clock.
// [RULE_04] Select high routes the alternate pair, low the primary pair.
// [RULE_05] Gate switches only after a rising then a falling selected edge.
// [RULE_06] Enable may change any time; synchronised so no runt appears.
// [RULE_07] Differential input: true follows true, complement inverts.
// [RULE_08] Complement biased: non-inverting single-ended to differential.
// [RULE_09] True biased, complement driven: outputs invert the complement.
// [RULE_10] Four identical output pairs carry the same waveform.
// [RULE_11] Undriven: output and gate enables default high, select low.
// [RULE_12] Enable captured on rising selected edge, applied at next falling.
`default_nettype none

module fcg_fanout_gate #(
   parameter int NUM_PAIRS = fcg_pkg::NUM_PAIRS
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Control pins
   input wire fcg_pkg::fcg_ctrl_s i_ctrl,
   // Clock input pairs
   input wire fcg_pkg::fcg_pair_s i_primary_clock_in,
   input wire fcg_pkg::fcg_pair_s i_alternate_clock_in,
   // Fanout pairs
   output logic [NUM_PAIRS-1:0] o_fanout_true_outputs,
   output logic [NUM_PAIRS-1:0] o_fanout_comp_outputs,
   output logic [NUM_PAIRS-1:0] o_fanout_oe
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [fcg_pkg::CTRL_W-1:0] ctrl_pin;
   logic [fcg_pkg::CTRL_W-1:0] ctrl_s;
   logic [fcg_pkg::PAIR_W-1:0] prim_s;
   logic [fcg_pkg::PAIR_W-1:0] alt_s;
   fcg_pkg::fcg_pair_s prim_pair;
   fcg_pkg::fcg_pair_s alt_pair;
   logic oe_s;
   logic en_s;
   logic sel_s;
   logic prim_lvl;
   logic alt_lvl;
   logic sel_level;
   logic level_prev_r;
   logic clk_rise;
   logic clk_fall;
   logic armed_r;
   logic gate_r;
   fcg_pkg::fcg_gate_e gate_state_r;
   fcg_pkg::fcg_gate_e gate_state_nxt;

   // ---------------------------------------------------------------
   // Control pin defaults
   // ---------------------------------------------------------------
   // [RULE_11] Pull levels
   always_comb begin
      ctrl_pin[fcg_pkg::CTRL_OE_BIT] =
         i_ctrl.oe_drv ? i_ctrl.oe : fcg_pkg::OE_PULL;
      ctrl_pin[fcg_pkg::CTRL_EN_BIT] =
         i_ctrl.en_drv ? i_ctrl.en : fcg_pkg::EN_PULL;
      ctrl_pin[fcg_pkg::CTRL_SEL_BIT] =
         i_ctrl.sel_drv ? i_ctrl.sel : fcg_pkg::SEL_PULL;
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // [RULE_06] Asynchronous enable captured
   fcg_sync3 #(
      .W(fcg_pkg::CTRL_W),
      .RST_VAL(fcg_pkg::CTRL_RST)
   ) u_sync_ctrl (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_async(ctrl_pin),
      .o_stable(ctrl_s)
   );

   fcg_sync3 #(
      .W(fcg_pkg::PAIR_W),
      .RST_VAL(fcg_pkg::PAIR_RST)
   ) u_sync_prim (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_async(i_primary_clock_in),
      .o_stable(prim_s)
   );

   fcg_sync3 #(
      .W(fcg_pkg::PAIR_W),
      .RST_VAL(fcg_pkg::PAIR_RST)
   ) u_sync_alt (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_async(i_alternate_clock_in),
      .o_stable(alt_s)
   );

   assign oe_s = ctrl_s[fcg_pkg::CTRL_OE_BIT];
   assign en_s = ctrl_s[fcg_pkg::CTRL_EN_BIT];
   assign sel_s = ctrl_s[fcg_pkg::CTRL_SEL_BIT];
   assign prim_pair = fcg_pkg::fcg_pair_s'(prim_s);
   assign alt_pair = fcg_pkg::fcg_pair_s'(alt_s);

   // ---------------------------------------------------------------
   // Input pair decode and source select
   // ---------------------------------------------------------------
   fcg_pair_decode u_dec_prim (
      .i_pair(prim_pair),
      .o_level(prim_lvl)
   );

   fcg_pair_decode u_dec_alt (
      .i_pair(alt_pair),
      .o_level(alt_lvl)
   );

   // [RULE_04] Source mux
   // A select change mid-period may shorten one pulse; switch while gated.
   assign sel_level = (sel_s == fcg_pkg::SEL_ALTERNATE) ? alt_lvl : prim_lvl;

   // ---------------------------------------------------------------
   // Selected clock edge detection
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         level_prev_r <= fcg_pkg::LEVEL_RST;
      end else begin
         level_prev_r <= sel_level;
      end
   end

   assign clk_rise = sel_level & ~level_prev_r;
   assign clk_fall = ~sel_level & level_prev_r;

   // ---------------------------------------------------------------
   // Enable gate: arm on rising edge, apply on falling edge
   // ---------------------------------------------------------------
   // [RULE_12] Arm on rising
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         armed_r <= fcg_pkg::GATE_RST;
      end else if (clk_rise) begin
         armed_r <= en_s;
      end
   end

   // [RULE_05] Apply on falling
   // Gate moves only while the clock is low, so no output edge is cut.
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         gate_r <= fcg_pkg::GATE_RST;
      end else if (clk_fall) begin
         gate_r <= armed_r;
      end
   end

   // Progress tracker, visible for debug and checks
   always_comb begin
      case (gate_state_r)
         fcg_pkg::GATE_IDLE: begin
            gate_state_nxt = (en_s != gate_r) ? fcg_pkg::GATE_ARMED
                                              : fcg_pkg::GATE_IDLE;
         end
         fcg_pkg::GATE_ARMED: begin
            gate_state_nxt = (clk_fall && armed_r != gate_r) ?
                             fcg_pkg::GATE_APPLIED : fcg_pkg::GATE_ARMED;
         end
         fcg_pkg::GATE_APPLIED: begin
            gate_state_nxt = fcg_pkg::GATE_IDLE;
         end
         default: begin
            gate_state_nxt = fcg_pkg::GATE_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         gate_state_r <= fcg_pkg::GATE_IDLE;
      end else begin
         gate_state_r <= gate_state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Fanout output registers
   // ---------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NUM_PAIRS; p = p + 1) begin : g_pair
         // [RULE_10] Identical copies
         always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               o_fanout_true_outputs[p] <= fcg_pkg::LEVEL_RST;
               o_fanout_comp_outputs[p] <= ~fcg_pkg::LEVEL_RST;
            end else begin
               // [RULE_02] Gated forces low
               // [RULE_03] Running follows clock
               o_fanout_true_outputs[p] <= gate_r & sel_level;
               o_fanout_comp_outputs[p] <= ~(gate_r & sel_level);
            end
         end

         // [RULE_01] Drive enable
         always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               o_fanout_oe[p] <= fcg_pkg::OE_PULL;
            end else begin
               o_fanout_oe[p] <= oe_s;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_rise_seen;
      $past(clk_rise);
   endsequence

   sequence s_fall_seen;
      $past(clk_fall);
   endsequence

   AST_HIZ_WHEN_OFF: assert property ( // [RULE_01]
      !oe_s |=> o_fanout_oe == '0)
      else $error("outputs driven while output enable low");

   AST_DRIVE_WHEN_ON: assert property ( // [RULE_01]
      oe_s |=> o_fanout_oe == '1)
      else $error("outputs not driven while output enable high");

   AST_GATED_LEVELS: assert property ( // [RULE_02]
      !gate_r |=> o_fanout_true_outputs == '0 &&
                  o_fanout_comp_outputs == '1)
      else $error("gated outputs not at low/high rest levels");

   AST_FOLLOW_CLOCK: assert property ( // [RULE_03]
      gate_r |=> o_fanout_true_outputs == {NUM_PAIRS{$past(sel_level)}})
      else $error("running outputs do not follow selected clock");

   AST_SOURCE_SELECT: assert property ( // [RULE_04]
      sel_s |-> sel_level == alt_lvl)
      else $error("alternate pair not routed when selected");

   AST_SOURCE_PRIMARY: assert property ( // [RULE_04]
      !sel_s |-> sel_level == prim_lvl)
      else $error("primary pair not routed when deselected");

   AST_GATE_ON_FALL: assert property ( // [RULE_05]
      $changed(gate_r) |-> s_fall_seen and ($past(armed_r) == gate_r))
      else $error("gate changed away from a falling edge");

   // Tracker and gate must agree, or debug views mislead
   AST_GATE_TRACK: assert property ( // [RULE_05]
      gate_state_r == fcg_pkg::GATE_APPLIED |-> $changed(gate_r))
      else $error("tracker reports a gate change that did not happen");

   AST_NO_RUNT: assert property ( // [RULE_06]
      $rose(o_fanout_true_outputs[0]) |-> $past(sel_level) &&
                                          $past(gate_r))
      else $error("output rose without a selected high level");

   AST_COMP_INVERSE: assert property ( // [RULE_07]
      o_fanout_comp_outputs == ~o_fanout_true_outputs)
      else $error("complement outputs are not the inverse");

   AST_SE_NONINV: assert property ( // [RULE_08]
      prim_pair.comp_bias && !prim_pair.true_bias |->
      prim_lvl == prim_pair.true_lvl)
      else $error("single-ended primary input inverted");

   AST_SE_INV: assert property ( // [RULE_09]
      prim_pair.true_bias && !prim_pair.comp_bias |->
      prim_lvl == !prim_pair.comp_lvl)
      else $error("biased-true primary input not inverted");

   AST_SAME_WAVE: assert property ( // [RULE_10]
      o_fanout_true_outputs == {NUM_PAIRS{o_fanout_true_outputs[0]}})
      else $error("fanout pairs disagree");

   AST_PULL_DEFAULTS: assert property ( // [RULE_11]
      !i_ctrl.en_drv && !i_ctrl.oe_drv && !i_ctrl.sel_drv |->
      ctrl_pin == fcg_pkg::CTRL_RST)
      else $error("undriven controls not at pull levels");

   AST_ARM_ON_RISE: assert property ( // [RULE_12]
      $changed(armed_r) |-> s_rise_seen and ($past(en_s) == armed_r))
      else $error("enable armed away from a rising edge");

endmodule : fcg_fanout_gate

`default_nettype wire

// [core/fcg_pair_decode.sv]
`default_nettype none

module fcg_pair_decode (
   // Input pair
   input wire fcg_pkg::fcg_pair_s i_pair,
   // Recovered logical clock level
   output logic o_level
);

   // ---------------------------------------------------------------
   // Differential, single-ended or inverted single-ended decode
   // ---------------------------------------------------------------
   always_comb begin
      if (i_pair.comp_bias && !i_pair.true_bias) begin
         // [RULE_08] True drives, non-inverting
         o_level = i_pair.true_lvl;
      end else if (i_pair.true_bias && !i_pair.comp_bias) begin
         // [RULE_09] Complement drives, inverting
         o_level = ~i_pair.comp_lvl;
      end else begin
         // [RULE_07] Differential follows true
         o_level = i_pair.true_lvl;
      end
   end

endmodule : fcg_pair_decode

`default_nettype wire

// [core/fcg_sync3.sv]
`default_nettype none

module fcg_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Pin side
   input wire logic [W-1:0] i_async,
   // Core side
   output logic [W-1:0] o_stable
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // ---------------------------------------------------------------
   // Per-bit three stage capture, accept on agreement
   // ---------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < W; b = b + 1) begin : g_bit
         always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               s1_r[b] <= RST_VAL[b];
               s2_r[b] <= RST_VAL[b];
               s3_r[b] <= RST_VAL[b];
            end else begin
               s1_r[b] <= i_async[b];
               s2_r[b] <= s1_r[b];
               s3_r[b] <= s2_r[b];
            end
         end

         // [RULE_06] Metastability filter
         always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               o_stable[b] <= RST_VAL[b];
            end else if (s2_r[b] == s3_r[b]) begin
               o_stable[b] <= s3_r[b];
            end
         end
      end
   endgenerate

   AST_SYNC_AGREE: assert property (@(posedge i_core_clk) // [RULE_06]
      disable iff (!i_resetn)
      ((o_stable ^ $past(o_stable)) & ($past(s2_r) ^ $past(s3_r))) == '0)
      else $error("stable output moved without stage agreement");

endmodule : fcg_sync3

`default_nettype wire

// [include/fcg_pkg.sv]
`default_nettype none

package fcg_pkg;

   // ---------------------------------------------------------------
   // Fanout geometry
   // ---------------------------------------------------------------
   localparam int NUM_PAIRS = 4;

   // ---------------------------------------------------------------
   // Levels taken by control pins left undriven
   // ---------------------------------------------------------------
   localparam logic OE_PULL = 1'h1;
   localparam logic EN_PULL = 1'h1;
   localparam logic SEL_PULL = 1'h0;

   // ---------------------------------------------------------------
   // Source select encoding
   // ---------------------------------------------------------------
   localparam logic SEL_PRIMARY = 1'h0;
   localparam logic SEL_ALTERNATE = 1'h1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   // Control vector order: {oe, en, sel}
   localparam int CTRL_W = 3;
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h6;
   localparam int CTRL_OE_BIT = 2;
   localparam int CTRL_EN_BIT = 1;
   localparam int CTRL_SEL_BIT = 0;
   localparam int PAIR_W = 4;
   localparam logic [PAIR_W-1:0] PAIR_RST = 4'h0;
   localparam logic GATE_RST = 1'h0;
   localparam logic LEVEL_RST = 1'h0;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   // One input pair: levels plus board bias straps
   typedef struct packed {
      logic true_lvl;
      logic comp_lvl;
      logic true_bias;
      logic comp_bias;
   } fcg_pair_s;

   // Control pins with a driven flag each; undriven takes the pull level
   typedef struct packed {
      logic oe;
      logic oe_drv;
      logic en;
      logic en_drv;
      logic sel;
      logic sel_drv;
   } fcg_ctrl_s;

   // Gate progress after an enable change
   typedef enum logic [1:0] {
      GATE_IDLE,
      GATE_ARMED,
      GATE_APPLIED
   } fcg_gate_e;

endpackage : fcg_pkg

`default_nettype wire

// [test/clock_fanout_select_gate_tb.sv]
`default_nettype none

`define CHK(what, exp, got) \
   begin \
      tests_run = tests_run + 1; \
      if ((got) !== (exp)) begin \
         mismatches = mismatches + 1; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end

module clock_fanout_select_gate_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   fcg_pkg::fcg_ctrl_s ctrl = '0;
   logic [1:0] p_mode = 2'h0;
   logic [1:0] a_mode = 2'h0;
   logic use_alt = 1'h0;
   fcg_pkg::fcg_pair_s p_pair;
   fcg_pkg::fcg_pair_s a_pair;
   logic p_lvl;
   logic a_lvl;
   logic [3:0] q_true;
   logic [3:0] q_comp;
   logic [3:0] q_oe;
   logic prev_q = 1'h0;
   int run_len = 100;
   int rises = 0;
   int cycles = 0;
   int mismatches = 0;
   int tests_run = 0;

   always #10 core_clk = ~core_clk;

   fcg_fanout_gate dut_u (
      .i_core_clk(core_clk),
      .i_resetn(resetn),
      .i_ctrl(ctrl),
      .i_primary_clock_in(p_pair),
      .i_alternate_clock_in(a_pair),
      .o_fanout_true_outputs(q_true),
      .o_fanout_comp_outputs(q_comp),
      .o_fanout_oe(q_oe)
   );

   // Different periods so a wrong source shows up as a phase error
   fcg_clk_src #(.HALF(10)) u_src_p (
      .i_core_clk(core_clk), .i_mode(p_mode), .o_pair(p_pair),
      .o_level(p_lvl));
   fcg_clk_src #(.HALF(14)) u_src_a (
      .i_core_clk(core_clk), .i_mode(a_mode), .o_pair(a_pair),
      .o_level(a_lvl));

   // ---------------------------------------------------------------
   // Monitors
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!resetn) begin
         run_len = 100;
      end else if (q_true[0] !== prev_q) begin
         `CHK("pulse_width", 1'h1, run_len >= 8)
         if (q_true[0] === 1'h1) rises = rises + 1;
         run_len = 0;
      end
      run_len = run_len + 1;
      prev_q = q_true[0];
   end

   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic set_ctrl(input logic oe, input logic en, input logic sel);
      ctrl = {oe, 1'h1, en, 1'h1, sel, 1'h1};
      use_alt = sel;
   endtask

   // Select is not runt protected, so it only moves while gated
   task automatic reselect(input logic sel);
      set_ctrl(1'h1, 1'h0, use_alt);
      wait_cyc(60);
      set_ctrl(1'h1, 1'h0, sel);
      wait_cyc(20);
   endtask

   // Sample mid half period, well past the synchroniser latency
   task automatic follow(input int n);
      logic l;
      for (int i = 0; i < n; i++) begin
         l = use_alt ? a_lvl : p_lvl;
         wait ((use_alt ? a_lvl : p_lvl) !== l);
         wait_cyc(8);
         l = use_alt ? a_lvl : p_lvl;
         `CHK("fanout_true", {4{l}}, q_true)
         `CHK("fanout_comp", {4{~l}}, q_comp)
      end
   endtask

   task automatic gated();
      `CHK("gated_true", 4'h0, q_true)
      `CHK("gated_comp", 4'hf, q_comp)
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      wait_cyc(20);
      gated();
      `CHK("reset_oe", 4'hf, q_oe)
      resetn = 1'h1;
      $display("done reset");
   endtask

   // Undriven pins with opposite values must be ignored
   task automatic t_defaults();
      ctrl = {1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
      use_alt = 1'h0;
      wait_cyc(80);
      `CHK("default_oe", 4'hf, q_oe)
      follow(4);
      $display("done defaults");
   endtask

   task automatic t_modes();
      for (int s = 0; s < 2; s++) begin
         for (int m = 0; m < 3; m++) begin
            set_ctrl(1'h1, 1'h0, use_alt);
            wait_cyc(60);
            gated();
            // Select is not runt protected, so change it while gated
            set_ctrl(1'h1, 1'h0, s[0]);
            if (s == 0) p_mode = m[1:0];
            else a_mode = m[1:0];
            wait_cyc(20);
            gated();
            set_ctrl(1'h1, 1'h1, s[0]);
            wait_cyc(80);
            follow(3);
         end
      end
      p_mode = 2'h0;
      $display("done modes");
   endtask

   task automatic t_gate_timing();
      reselect(1'h0);
      set_ctrl(1'h1, 1'h1, 1'h0);
      wait_cyc(80);
      wait (p_lvl === 1'h0);
      wait (p_lvl === 1'h1);
      wait_cyc(2);
      ctrl.en = 1'h0;
      rises = 0;
      wait_cyc(50);
      `CHK("rises_after_off", 2, rises)
      gated();
      wait (p_lvl === 1'h1);
      wait_cyc(2);
      ctrl.en = 1'h1;
      rises = 0;
      wait_cyc(50);
      `CHK("rises_after_on", 1, rises)
      $display("done gate timing");
   endtask

   task automatic t_runt();
      reselect(1'h1);
      set_ctrl(1'h1, 1'h1, 1'h1);
      wait_cyc(80);
      // enable dropped for 1 to 13 cycles, at shifting phases of the input clock
      for (int k = 1; k < 14; k++) begin
         ctrl.en = 1'h0;
         wait_cyc(k);
         ctrl.en = 1'h1;
         wait_cyc(k + 3);
      end
      wait_cyc(100);
      follow(2);
      $display("done runt");
   endtask

   task automatic t_oe();
      for (int i = 0; i < 4; i++) begin
         reselect(i[0]);
         set_ctrl(1'h1, i[1], i[0]);
         wait_cyc(80);
         set_ctrl(1'h0, i[1], i[0]);
         wait_cyc(10);
         `CHK("oe_off", 4'h0, q_oe)
         `CHK("comp_inverse", ~q_true, q_comp)
         if (!i[1]) gated();
         set_ctrl(1'h1, i[1], i[0]);
         wait_cyc(10);
         `CHK("oe_on", 4'hf, q_oe)
      end
      $display("done output enable");
   endtask

   task automatic t_midreset();
      resetn = 1'h0;
      #1;
      gated();
      `CHK("midreset_oe", 4'hf, q_oe)
      wait_cyc(3);
      resetn = 1'h1;
      wait_cyc(100);
      follow(2);
      $display("done mid reset");
   endtask

   initial begin
      t_reset();
      t_defaults();
      t_modes();
      t_gate_timing();
      t_runt();
      t_oe();
      t_midreset();
      conclude();
   end

endmodule // clock_fanout_select_gate_tb

`default_nettype wire

// [test/fcg_clk_src.sv]
`default_nettype none

module fcg_clk_src #(
   parameter int HALF = 10
) (
   // Clock
   input wire logic i_core_clk,
   // Wiring mode: 0 differential, 1 complement biased, 2 true biased
   input wire logic [1:0] i_mode,
   // Pair to the block and logical level for the bench
   output var fcg_pkg::fcg_pair_s o_pair,
   output var logic o_level
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Free running source
   // ---------------------------------------------------------------
   int cnt_r = 0;
   logic junk_r = 1'h0;

   initial o_level = 1'h0;

   // Biased leg carries no logic level; toggle it so nothing reads it
   always @(posedge i_core_clk) begin
      #1;
      junk_r = ~junk_r;
      cnt_r = cnt_r + 1;
      if (cnt_r >= HALF) begin
         cnt_r = 0;
         o_level = ~o_level;
      end
   end

   // ---------------------------------------------------------------
   // Pair wiring
   // ---------------------------------------------------------------
   always_comb begin
      o_pair = '0;
      case (i_mode)
         2'h1: begin
            o_pair.true_lvl = o_level;
            o_pair.comp_lvl = junk_r;
            o_pair.comp_bias = 1'h1;
         end
         2'h2: begin
            o_pair.true_lvl = junk_r;
            o_pair.comp_lvl = ~o_level;
            o_pair.true_bias = 1'h1;
         end
         default: begin
            o_pair.true_lvl = o_level;
            o_pair.comp_lvl = ~o_level;
         end
      endcase
   end

endmodule // fcg_clk_src

`default_nettype wire
